// [design/cetr_pkg.sv]
package cetr_pkg;
  localparam int CETR_FATAL_BIT = 24;
  localparam int CETR_BOTH_BIT = 25;
  localparam int CETR_TAGERR_BIT = 28;
  localparam int CETR_DATAERR_BIT = 29;
  localparam int CETR_SCRATCH_BIT = 23;
  localparam int CETR_WAYERR_BIT = 22;
  localparam int CETR_WAY_LSB = 20;
  localparam int CETR_IDX_MSB = 19;
  localparam int CETR_PA_LSB = 10;
  localparam int CETR_VALID_BIT = 7;
  localparam int CETR_DIRTY_BIT = 6;
  localparam int CETR_LOCK_BIT = 5;
  localparam int CETR_WSD_LSB = 16;
  localparam int CETR_LRU_LSB = 10;
  localparam int CETR_VIEW_BIT = 29;
  localparam logic [31:0] CETR_ERR_RESET = 32'h0000_0000;
  localparam logic [31:0] CETR_TAG_RESET = 32'h0000_0000;
  localparam logic [31:0] CETR_CTL_RESET = 32'h0000_0000;
  localparam logic [31:0] CETR_TAG_MASK = 32'hFFFF_FCE0;
  localparam logic [31:0] CETR_WAY_MASK = 32'h000F_FC00;
  localparam logic [31:0] CETR_CTL_MASK = 32'h2000_0000;
  localparam logic [19:0] CETR_TAGERR_IDX_MASK = 20'hFFFE7;
  localparam logic [19:0] CETR_CACHE_IDX_MASK = 20'h0FFFF;

  // Parity error event from the cache arrays
  typedef struct packed {
    logic valid;
    logic instrErr;
    logic dataErr;
    logic tagErr;
    logic dataRamErr;
    logic scratchErr;
    logic wayErr;
    logic dirtyVictimErr;
    logic wbMissWayErr;
    logic [1:0] way;
    logic [19:0] index;
  } cetr_err_evt_t;

  // Register write strobes and data
  typedef struct packed {
    logic wrErrReport;
    logic wrTag;
    logic wrCtl;
    logic [31:0] data;
  } cetr_reg_wr_t;

  // Indexed tag operation request
  typedef struct packed {
    logic loadTag;
    logic storeTag;
    logic storeData;
  } cetr_tag_op_t;
endpackage

// [design/cetr_err_capture.sv]
`timescale 1ns/1ps
module cetr_err_capture (
  input wire logic core_clk,
  input wire logic rstSync,
  input wire cetr_pkg::cetr_err_evt_t evt,
  input wire logic wrEn,
  input wire logic [31:0] wrData,
  output logic [31:0] errReport
);
  import cetr_pkg::*;

  logic fatal;
  logic [1:0] wayField;
  logic [19:0] idxMasked;
  logic [31:0] next_errReport;
  logic bothSides;

  assign bothSides = evt.instrErr && evt.dataErr;
  // Data-side only chain never sets fatal by itself
  assign fatal = evt.dirtyVictimErr || evt.wbMissWayErr;
  assign wayField = (evt.tagErr || evt.scratchErr) ? 2'h0 : evt.way;
  assign idxMasked = evt.index
    & (evt.tagErr ? CETR_TAGERR_IDX_MASK : 20'hFFFFF)
    & (evt.scratchErr ? 20'hFFFFF : CETR_CACHE_IDX_MASK);

  always_comb begin
    next_errReport = errReport;
    if (evt.valid) begin
      next_errReport = 32'h0000_0000;
      next_errReport[CETR_DATAERR_BIT] = evt.dataRamErr && !bothSides;
      next_errReport[CETR_TAGERR_BIT] = evt.tagErr;
      next_errReport[CETR_BOTH_BIT] = bothSides;
      next_errReport[CETR_FATAL_BIT] = fatal;
      next_errReport[CETR_SCRATCH_BIT] = evt.scratchErr;
      next_errReport[CETR_WAYERR_BIT] = evt.wayErr;
      next_errReport[CETR_WAY_LSB +: 2] = wayField;
      next_errReport[CETR_IDX_MSB:0] = idxMasked;
    end else if (wrEn) begin
      next_errReport[27] = wrData[27];
    end
  end

  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      errReport <= CETR_ERR_RESET;
    end else begin
      errReport <= next_errReport;
    end
  end

  a_fatal_capture: assert property (@(posedge core_clk) disable iff (!rstSync)
    evt.valid |=> errReport[CETR_FATAL_BIT] == $past(fatal))
    else $error("fatal flag mismatch");
  a_way_invalid: assert property (@(posedge core_clk) disable iff (!rstSync)
    evt.valid && (evt.tagErr || evt.scratchErr) |=> errReport[21:20] == 2'h0)
    else $error("way field not cleared");
endmodule

// [design/cetr_cache_diag.sv]
`timescale 1ns/1ps
module cetr_cache_diag (
  input wire logic core_clk,
  input wire logic resetn,
  input wire cetr_pkg::cetr_err_evt_t errEvt,
  input wire cetr_pkg::cetr_reg_wr_t regWr,
  input wire cetr_pkg::cetr_tag_op_t tagOp,
  input wire logic [31:0] tagArrayRd,
  input wire logic [31:0] wayArrayRd,
  input wire logic [3:0] candValid,
  input wire logic [3:0] candLock,
  input wire logic [1:0] lruVictim,
  output logic [31:0] errReport,
  output logic [31:0] tagIfRead,
  output logic [31:0] ctlRead,
  output logic tagArrayWe,
  output logic wayArrayWe,
  output logic dataArrayWe,
  output logic [31:0] arrayWrData,
  output logic [1:0] victimWay,
  output logic victimValid
);
  import cetr_pkg::*;

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic rstMeta;
  logic rstSync;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // ------------------------------------------------------------
  // Error report
  // ------------------------------------------------------------
  cetr_err_capture errCap (
    .core_clk(core_clk),
    .rstSync(rstSync),
    .evt(errEvt),
    .wrEn(regWr.wrErrReport),
    .wrData(regWr.data),
    .errReport(errReport)
  );

  // ------------------------------------------------------------
  // Control and tag interface
  // ------------------------------------------------------------
  logic [31:0] ctlReg;
  logic [31:0] tagReg;
  logic wayView;
  logic [31:0] viewMask;
  logic [31:0] loadSrc;
  logic [31:0] next_tagReg;
  logic [31:0] tagFixed;

  assign wayView = ctlReg[CETR_VIEW_BIT];
  assign viewMask = wayView ? CETR_WAY_MASK : CETR_TAG_MASK;
  assign loadSrc = wayView ? wayArrayRd : tagArrayRd;

  always_comb begin
    tagFixed = regWr.data & viewMask;
    // Dirty only with valid
    if (!wayView && !tagFixed[CETR_VALID_BIT]) begin
      tagFixed[CETR_DIRTY_BIT] = 1'b0;
    end
  end

  always_comb begin
    next_tagReg = tagReg;
    if (tagOp.loadTag) begin
      next_tagReg = loadSrc & viewMask;
      if (!wayView && !loadSrc[CETR_VALID_BIT]) begin
        next_tagReg[CETR_DIRTY_BIT] = 1'b0;
      end
    end else if (regWr.wrTag) begin
      next_tagReg = tagFixed;
    end
  end

  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      ctlReg <= CETR_CTL_RESET;
      tagReg <= CETR_TAG_RESET;
    end else begin
      if (regWr.wrCtl) begin
        ctlReg <= regWr.data & CETR_CTL_MASK;
      end
      tagReg <= next_tagReg;
    end
  end

  // ------------------------------------------------------------
  // Array writes and views
  // ------------------------------------------------------------
  logic [3:0] eligible;
  logic [1:0] next_victim;
  logic next_victimValid;
  logic [31:0] next_tagIfRead;

  assign next_tagIfRead = next_tagReg & viewMask;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gEl
      assign eligible[g] = !(candLock[g] && candValid[g]);
    end
  endgenerate

  always_comb begin
    next_victim = lruVictim;
    next_victimValid = eligible[lruVictim];
    if (!eligible[lruVictim]) begin
      for (int i = 3; i >= 0; i--) begin
        if (eligible[i]) begin
          next_victim = 2'(i);
          next_victimValid = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      tagIfRead <= 32'h0000_0000;
      ctlRead <= 32'h0000_0000;
      tagArrayWe <= 1'b0;
      wayArrayWe <= 1'b0;
      dataArrayWe <= 1'b0;
      arrayWrData <= 32'h0000_0000;
      victimWay <= 2'h0;
      victimValid <= 1'b0;
    end else begin
      tagIfRead <= next_tagIfRead;
      ctlRead <= regWr.wrCtl ? (regWr.data & CETR_CTL_MASK) : ctlReg;
      tagArrayWe <= tagOp.storeTag && !wayView;
      wayArrayWe <= tagOp.storeTag && wayView;
      dataArrayWe <= tagOp.storeData && wayView;
      arrayWrData <= tagReg;
      victimWay <= next_victim;
      victimValid <= next_victimValid;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_dirty_needs_valid: assert property (@(posedge core_clk) disable iff (!rstSync)
    !wayView |-> !(tagReg[CETR_DIRTY_BIT] && !tagReg[CETR_VALID_BIT]))
    else $error("dirty without valid");
  a_tag_zero_bits: assert property (@(posedge core_clk) disable iff (!rstSync)
    (tagIfRead & ~CETR_TAG_MASK & ~CETR_WAY_MASK) == 32'h0)
    else $error("unimplemented tag bits set");
  a_way_zero_bits: assert property (@(posedge core_clk) disable iff (!rstSync)
    $past(wayView) && wayView |-> (tagIfRead & ~CETR_WAY_MASK) == 32'h0)
    else $error("unimplemented way bits set");
  a_load_way_view: assert property (@(posedge core_clk) disable iff (!rstSync)
    tagOp.loadTag && wayView |=> tagReg == ($past(wayArrayRd) & CETR_WAY_MASK))
    else $error("way load mismatch");
  a_store_select: assert property (@(posedge core_clk) disable iff (!rstSync)
    tagOp.storeTag |=> (tagArrayWe != wayArrayWe) && wayArrayWe == $past(wayView))
    else $error("store went to wrong array");
  a_store_data_gate: assert property (@(posedge core_clk) disable iff (!rstSync)
    dataArrayWe |-> $past(wayView))
    else $error("store data without view bit");
  a_no_locked_victim: assert property (@(posedge core_clk) disable iff (!rstSync)
    victimValid |-> ((($past(candLock) & $past(candValid)) >> victimWay) & 4'h1) == 4'h0)
    else $error("locked line chosen");
  a_scratch_flag: assert property (@(posedge core_clk) disable iff (!rstSync)
    errEvt.valid |=> errReport[CETR_SCRATCH_BIT] == $past(errEvt.scratchErr))
    else $error("scratchpad flag mismatch");
  a_wayerr_flag: assert property (@(posedge core_clk) disable iff (!rstSync)
    errEvt.valid |=> errReport[CETR_WAYERR_BIT] == $past(errEvt.wayErr))
    else $error("way error flag mismatch");
  a_high_index: assert property (@(posedge core_clk) disable iff (!rstSync)
    errEvt.valid && !errEvt.scratchErr |=> errReport[19:16] == 4'h0)
    else $error("high index used for cache error");
  a_ctl_view_only: assert property (@(posedge core_clk) disable iff (!rstSync)
    (ctlRead & ~CETR_CTL_MASK) == 32'h0)
    else $error("control reads unimplemented bits");
  a_tag_view_zero: assert property (@(posedge core_clk) disable iff (!rstSync)
    !$past(wayView) && !wayView |-> (tagIfRead & ~CETR_TAG_MASK) == 32'h0)
    else $error("tag view unimplemented bits set");
  a_read_dirty_valid: assert property (@(posedge core_clk) disable iff (!rstSync)
    !$past(wayView) |-> !(tagIfRead[CETR_DIRTY_BIT] && !tagIfRead[CETR_VALID_BIT]))
    else $error("read shows dirty without valid");

  c_fatal: cover property (@(posedge core_clk) errEvt.valid && errEvt.dirtyVictimErr);
  c_way_load: cover property (@(posedge core_clk) tagOp.loadTag && wayView);
  c_tag_store: cover property (@(posedge core_clk) tagOp.storeTag && !wayView);
  c_both_sides: cover property (@(posedge core_clk) errEvt.valid && errEvt.instrErr && errEvt.dataErr);
  c_lock_skip: cover property (@(posedge core_clk) victimValid && victimWay != $past(lruVictim));
endmodule

// [tb/cetr_array_model.sv]
`timescale 1ns/1ps
module cetr_array_model (
  input wire logic core_clk,
  input wire logic tagArrayWe,
  input wire logic wayArrayWe,
  input wire logic dataArrayWe,
  input wire logic [31:0] arrayWrData,
  output logic [31:0] tagArrayRd,
  output logic [31:0] wayArrayRd
);
  // ----------------------------------
  // Tag and way arrays, unimplemented bits set; data array starts at zero
  // ----------------------------------
  logic [31:0] tagMem = 32'hFFFF_FFFF;
  logic [31:0] wayMem = 32'hFFFF_FFFF;
  logic [31:0] dataMem = 32'h0000_0000;
  always @(posedge core_clk) begin
    if (tagArrayWe) tagMem <= arrayWrData;
    if (wayArrayWe) wayMem <= arrayWrData;
    if (dataArrayWe) dataMem <= arrayWrData;
  end
  assign tagArrayRd = tagMem;
  assign wayArrayRd = wayMem;
endmodule

// [tb/test_cache_error_and_tag_interface.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_cache_error_and_tag_interface;
  import cetr_pkg::*;
  typedef struct packed {
    cetr_err_evt_t evt;
    logic [31:0] exp;
  } cetr_row_t;
  localparam logic T = 1'h1;
  localparam logic F = 1'h0;
  localparam cetr_row_t ROWS [5] = '{
    '{'{T, F, F, F, T, F, F, T, F, 2'h2, 20'h12345},
      32'h2120_2345},
    '{'{T, F, F, T, F, F, F, F, F, 2'h3, 20'hFFFFF},
      32'h1000_FFE7},
    '{'{T, F, F, F, F, T, F, F, F, 2'h1, 20'hFFFFF},
      32'h008F_FFFF},
    '{'{T, F, F, F, F, F, T, F, T, 2'h1, 20'h00018},
      32'h0150_0018},
    '{'{T, T, T, F, T, F, F, F, F, 2'h0, 20'h00008},
      32'h0200_0008}
  };
  logic core_clk;
  logic resetn;
  cetr_err_evt_t errEvt;
  cetr_reg_wr_t regWr;
  cetr_tag_op_t tagOp;
  logic [31:0] tagArrayRd, wayArrayRd, errReport, tagIfRead, ctlRead, arrayWrData;
  logic [3:0] candValid, candLock;
  logic [1:0] lruVictim, victimWay;
  logic tagArrayWe, wayArrayWe, dataArrayWe, victimValid;
  int error_cnt = 0;
  int n_checks = 0;
  cetr_cache_diag cetr_cache_diag_i (.core_clk(core_clk), .resetn(resetn), .errEvt(errEvt),
    .regWr(regWr), .tagOp(tagOp), .tagArrayRd(tagArrayRd), .wayArrayRd(wayArrayRd),
    .candValid(candValid), .candLock(candLock), .lruVictim(lruVictim),
    .errReport(errReport), .tagIfRead(tagIfRead), .ctlRead(ctlRead),
    .tagArrayWe(tagArrayWe), .wayArrayWe(wayArrayWe), .dataArrayWe(dataArrayWe),
    .arrayWrData(arrayWrData), .victimWay(victimWay), .victimValid(victimValid));
  cetr_array_model cetr_array_model_i (.core_clk(core_clk), .tagArrayWe(tagArrayWe),
    .wayArrayWe(wayArrayWe), .dataArrayWe(dataArrayWe), .arrayWrData(arrayWrData),
    .tagArrayRd(tagArrayRd), .wayArrayRd(wayArrayRd));
  // ----------------------------------
  // Clock, tasks and closing
  // ----------------------------------
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic tick();
    @(posedge core_clk);
    #1;
    regWr = {3'h0, regWr.data};
    tagOp = 3'h0;
    errEvt.valid = 1'h0;
  endtask
  task automatic wreg(input logic [2:0] sel, input logic [31:0] d);
    regWr = {sel, d};
    tick();
  endtask
  task automatic op(input logic [2:0] o);
    tagOp = o;
    tick();
  endtask
  task automatic tdone(input string name);
    $display("test %s done", name);
  endtask
  initial begin
    #20us;
    error_cnt++;
    $display("watchdog expired");
    end_of_test();
  end
  // ----------------------------------
  // Tests
  // ----------------------------------
  initial begin
    resetn = 1'h0;
    errEvt = '0;
    regWr = '0;
    tagOp = '0;
    candValid = 4'h0;
    candLock = 4'h0;
    lruVictim = 2'h0;
    repeat (12) @(posedge core_clk);
    #1 resetn = 1'h1;
    repeat (2) @(posedge core_clk);
    #1;
    `CHK({errReport, tagIfRead, ctlRead}, {CETR_ERR_RESET, CETR_TAG_RESET, CETR_CTL_RESET})
    tdone("reset");
    foreach (ROWS[i]) begin
      errEvt = ROWS[i].evt;
      tick();
      `CHK(errReport, ROWS[i].exp)
    end
    wreg(3'h4, 32'hFFFF_FFFF);
    `CHK(errReport, 32'h0A00_0008)
    tdone("error report");
    op(3'h4);
    `CHK(tagIfRead, 32'hFFFF_FCE0)
    wreg(3'h2, 32'hABCD_E7FF);
    `CHK(tagIfRead, 32'hABCD_E4E0)
    op(3'h2);
    `CHK({tagArrayWe, wayArrayWe, arrayWrData}, {2'h2, 32'hABCD_E4E0})
    op(3'h1);
    `CHK(dataArrayWe, 1'h0)
    wreg(3'h2, 32'h0000_0040);
    `CHK(tagIfRead, 32'h0000_0000)
    op(3'h4);
    `CHK(tagIfRead, 32'hABCD_E4E0)
    tdone("tag view");
    wreg(3'h1, 32'hFFFF_FFFF);
    `CHK(ctlRead, 32'h2000_0000)
    wreg(3'h2, 32'hFFF5_57FF);
    `CHK(tagIfRead, 32'h0005_5400)
    op(3'h4);
    `CHK(tagIfRead, 32'h000F_FC00)
    wreg(3'h2, 32'hFFF5_57FF);
    op(3'h2);
    `CHK({tagArrayWe, wayArrayWe, arrayWrData}, {2'h1, 32'h0005_5400})
    op(3'h1);
    `CHK(dataArrayWe, 1'h1)
    wreg(3'h2, 32'h0000_0000);
    op(3'h4);
    `CHK(tagIfRead, 32'h0005_5400)
    tdone("way view");
    candValid = 4'hF;
    candLock = 4'h2;
    lruVictim = 2'h1;
    tick();
    `CHK({victimValid, victimWay}, 3'h4)
    candLock = 4'hF;
    tick();
    `CHK(victimValid, 1'h0)
    candValid = 4'h0;
    tick();
    `CHK({victimValid, victimWay}, 3'h5)
    tdone("victim");
    resetn = 1'h0;
    #2;
    `CHK({errReport, tagIfRead, ctlRead}, 96'h0)
    tdone("second reset");
    end_of_test();
  end
endmodule
